/* File: shared/tmr_pkg.sv */
// constants and types for the timer pair run, cascade and clock-gate control
package tmr_pkg;
  localparam logic [11:0] TMR_CTRL_ADDR  = 12'h02c;
  localparam logic [11:0] TMR_GATE_ADDR  = 12'hf74;
  localparam logic [11:0] TMR_MODE0_ADDR = 12'h030;
  localparam logic [11:0] TMR_MODE1_ADDR = 12'h034;
  localparam logic [11:0] TMR_CNTLO_ADDR = 12'h038;
  localparam logic [11:0] TMR_CNTHI_ADDR = 12'h03c;
  localparam int TMR_RUN0_BIT = 0;
  localparam int TMR_RUN1_BIT = 1;
  localparam int TMR_CASC_BIT = 2;
  localparam int TMR_COMB_BIT = 3;
  localparam int TMR_CKEN_BIT = 4;
  localparam int TMR_EXT_BIT  = 3;
  localparam logic [7:0] TMR_GATE_RST = 8'h00;
  localparam logic [3:0] TMR_MODE_RST = 4'h0;
  localparam int TMR_PRE_W = 11;
  // gear divider exponent per clock-select code, index = code
  localparam logic [7:0][3:0] TMR_GEAR_EXP =
    {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hb};
  // low-frequency divider exponents for codes 000, 001, 111
  localparam logic [3:0] TMR_FS_EXP0 = 4'h4;
  localparam logic [3:0] TMR_FS_EXP1 = 4'h3;
  localparam logic [3:0] TMR_FS_EXP7 = 4'h2;
  typedef enum logic [1:0] {
    TMR_PWR_NORMAL = 2'h0,
    TMR_PWR_IDLE   = 2'h1,
    TMR_PWR_SLOW   = 2'h2,
    TMR_PWR_SLEEP  = 2'h3
  } tmr_pwr_e;
endpackage : tmr_pkg

/* File: shared/tmr_src_if.sv */
// source clock selection signals for one timer
`timescale 1ns/1ns
interface tmr_src_if;
  logic [10:0] pre;
  logic [3:0]  fsdiv;
  logic        fs_rise;
  logic        low_pwr;
  logic        dv9;
  logic [2:0]  code;
  logic        ext;
  logic        ev_fall;
  logic        tick;
  modport ctl (output pre, fsdiv, fs_rise, low_pwr, dv9, code, ext,
               ev_fall, input tick);
  modport sel (input pre, fsdiv, fs_rise, low_pwr, dv9, code, ext,
               ev_fall, output tick);
endinterface : tmr_src_if

/* File: rtl/tmr_sync_fall.sv */
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ns
module tmr_sync_fall
  import tmr_pkg::*;
#(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // pins and edges
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tmr_sync_s;
  tmr_sync_s st_q;
  tmr_sync_s st_d;

  if (W < 1)
  begin : g_chk
    $error("tmr_sync_fall: W must be at least 1");
  end

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rise = st_q.s2 & ~st_q.s3;
  assign fall = ~st_q.s2 & st_q.s3;
endmodule : tmr_sync_fall

/* File: rtl/tmr_src_sel.sv */
// source clock tick selection for one timer
`timescale 1ns/1ns
module tmr_src_sel
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // selection
  tmr_src_if.sel   s
);
  logic [10:0] gmask;
  logic [3:0]  fexp;
  logic [3:0]  fmask;
  logic        fs_ok;

  always_comb
  begin
    gmask  = 11'((12'h1 << TMR_GEAR_EXP[s.code]) - 12'h1);
    fexp   = (s.code == 3'h0) ? TMR_FS_EXP0 :
             (s.code == 3'h1) ? TMR_FS_EXP1 : TMR_FS_EXP7;
    fmask  = 4'((5'h1 << fexp) - 5'h1);
    // a stalled low-freq clock never rises, so no low-freq tick ever comes
    fs_ok  = s.fs_rise && ((s.fsdiv & fmask) == fmask);
    s.tick = 1'b0;
    if (s.ext)
      s.tick = s.ev_fall;
    else if (s.low_pwr)
    begin
      if (s.code == 3'h0 || s.code == 3'h1 || s.code == 3'h7)
        s.tick = fs_ok;
    end
    else if (s.dv9 && s.code <= 3'h1)
      s.tick = fs_ok;
    else
      s.tick = ((s.pre & gmask) == gmask);
  end

  slow_no_gear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (s.low_pwr && !s.ext && s.code inside {[3'h2:3'h6]}) |-> !s.tick)
    else $error("gear division reached a timer in a low power state");
endmodule : tmr_src_sel

/* File: rtl/tmr_pair_ctrl.sv */
// run, cascade, output combine and clock gating for a pair of 8-bit timers
`timescale 1ns/1ns
module tmr_pair_ctrl
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // register port
  input  wire logic [11:0]    addr,
  input  wire logic [7:0]     wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output logic      [7:0]     rdata,
  // system state
  input  tmr_pkg::tmr_pwr_e   pwr_state,
  input  wire logic           stop_entry,
  input  wire logic           divider_stage_clock_select,
  input  wire logic           low_freq_clock,
  // event pins
  input  wire logic [1:0]     timer_event_input_pin,
  // output pins
  output logic                timer0_pwm_out_pin,
  output logic                timer0_pulse_out_pin,
  output logic                timer1_pwm_out_pin,
  output logic                timer1_pulse_out_pin,
  // status
  output logic                timer_pair_clock_enable
);
  import tmr_pkg::*;

  typedef struct packed {
    logic        run0;
    logic        run1;
    logic        casc;
    logic        comb;
    logic [7:0]  gate;
    logic [3:0]  mode0;
    logic [3:0]  mode1;
    logic [15:0] cnt;
    logic        out0;
    logic        out1;
    logic        pin0;
    logic        pin1;
    logic [7:0]  rdata;
    logic [10:0] pre;
    logic [3:0]  fsdiv;
  } tmr_top_s;

  tmr_top_s st_q;
  tmr_top_s st_d;

  logic [2:0] ev_rise;
  logic [2:0] ev_fall;
  logic [1:0] tick;
  logic       cken;
  logic       low_pwr;
  logic       busy;
  logic       wr_ctrl;

  // event pins and low-freq clock come from outside this clock domain
  tmr_sync_fall #(
    .W (3)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({low_freq_clock, timer_event_input_pin}),
    .rise (ev_rise),
    .fall (ev_fall)
  );

  tmr_src_if src_if[2] ();

  for (genvar i = 0; i < 2; i++)
  begin : g_src
    assign src_if[i].pre     = st_q.pre;
    assign src_if[i].fsdiv   = st_q.fsdiv;
    assign src_if[i].fs_rise = ev_rise[2];
    assign src_if[i].low_pwr = low_pwr;
    assign src_if[i].dv9     = divider_stage_clock_select;
    assign src_if[i].code    = (i == 0) ? st_q.mode0[2:0]
                                        : st_q.mode1[2:0];
    assign src_if[i].ext     = (i == 0) ? st_q.mode0[TMR_EXT_BIT]
                                        : st_q.mode1[TMR_EXT_BIT];
    // cascaded pair counts on timer 0's pin only
    assign src_if[i].ev_fall = (i == 0 || st_q.casc) ? ev_fall[0]
                                                     : ev_fall[1];
    assign tick[i]           = src_if[i].tick;
    tmr_src_sel u_sel (
      .clk  (clk),
      .nrst (nrst),
      .s    (src_if[i])
    );
  end

  assign cken    = st_q.gate[TMR_CKEN_BIT];
  assign low_pwr = (pwr_state == TMR_PWR_SLOW) ||
                   (pwr_state == TMR_PWR_SLEEP);
  assign busy    = st_q.run0 || st_q.run1;
  assign wr_ctrl = wr && (addr == TMR_CTRL_ADDR);

  always_comb
  begin
    st_d = st_q;

    // prescalers only run with the basic clock supplied
    if (cken)
    begin
      st_d.pre = st_q.pre + 11'h1;
      if (ev_rise[2])
        st_d.fsdiv = st_q.fsdiv + 4'h1;
    end

    // register writes
    if (wr_ctrl)
    begin
      st_d.run0 = wdata[TMR_RUN0_BIT];
      st_d.run1 = wdata[TMR_RUN1_BIT];
      // config is frozen while running, but loads alongside a start
      if (!busy)
      begin
        st_d.casc = wdata[TMR_CASC_BIT];
        st_d.comb = wdata[TMR_COMB_BIT];
      end
    end
    if (wr && addr == TMR_GATE_ADDR)
      st_d.gate = wdata;
    if (wr && addr == TMR_MODE0_ADDR &&
        !st_q.run0 && !(st_q.casc && st_q.run1))
      st_d.mode0 = wdata[3:0];
    if (wr && addr == TMR_MODE1_ADDR && !st_q.run1)
      st_d.mode1 = wdata[3:0];

    // deep stop beats a software start in the same cycle
    if (stop_entry)
    begin
      st_d.run0 = 1'b0;
      st_d.run1 = 1'b0;
    end

    // counting uses the registered run bits; a new start counts next cycle
    if (st_q.casc)
    begin
      // one 16-bit counter run by timer 1, clocked by its select
      if (!st_q.run1)
      begin
        st_d.cnt  = 16'h0000;
        st_d.out0 = 1'b0;
        st_d.out1 = 1'b0;
      end
      else if (cken && tick[1])
      begin
        st_d.cnt = st_q.cnt + 16'h0001;
        if (st_q.cnt[7:0] == 8'hff)
          st_d.out0 = !st_q.out0;
        if (st_q.cnt == 16'hffff)
          st_d.out1 = !st_q.out1;
      end
    end
    else
    begin
      if (!st_q.run0)
      begin
        st_d.cnt[7:0] = 8'h00;
        st_d.out0     = 1'b0;
      end
      else if (cken && tick[0])
      begin
        st_d.cnt[7:0] = st_q.cnt[7:0] + 8'h01;
        if (st_q.cnt[7:0] == 8'hff)
          st_d.out0 = !st_q.out0;
      end
      if (!st_q.run1)
      begin
        st_d.cnt[15:8] = 8'h00;
        st_d.out1      = 1'b0;
      end
      else if (cken && tick[1])
      begin
        st_d.cnt[15:8] = st_q.cnt[15:8] + 8'h01;
        if (st_q.cnt[15:8] == 8'hff)
          st_d.out1 = !st_q.out1;
      end
    end

    // pins 0 idle high when combined, pins 1 carry the AND
    st_d.pin0 = st_q.comb ? 1'b1 : st_q.out0;
    st_d.pin1 = st_q.comb ? (st_q.out0 & st_q.out1)
                          : st_q.out1;

    // read data stand for the one cycle after the strobe
    st_d.rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        TMR_CTRL_ADDR:
          st_d.rdata = {4'h0, st_q.comb, st_q.casc,
                        st_q.run1, st_q.run0};
        TMR_GATE_ADDR:  st_d.rdata = st_q.gate;
        TMR_MODE0_ADDR: st_d.rdata = {4'h0, st_q.mode0};
        TMR_MODE1_ADDR: st_d.rdata = {4'h0, st_q.mode1};
        TMR_CNTLO_ADDR: st_d.rdata = st_q.cnt[7:0];
        TMR_CNTHI_ADDR: st_d.rdata = st_q.cnt[15:8];
        default:        st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q       <= '0;
      st_q.gate  <= TMR_GATE_RST;
      st_q.mode0 <= TMR_MODE_RST;
      st_q.mode1 <= TMR_MODE_RST;
    end
    else
      st_q <= st_d;
  end

  assign rdata                   = st_q.rdata;
  assign timer0_pwm_out_pin      = st_q.pin0;
  assign timer0_pulse_out_pin    = st_q.pin0;
  assign timer1_pwm_out_pin      = st_q.pin1;
  assign timer1_pulse_out_pin    = st_q.pin1;
  assign timer_pair_clock_enable = cken;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  read_upper_zero_a: assert property (
    (rd && addr == TMR_CTRL_ADDR) |=> (rdata[7:4] == 4'h0))
    else $error("control read shows nonzero upper bits");

  cfg_locked_a: assert property (
    (wr_ctrl && busy) |=> ($stable(st_q.casc) && $stable(st_q.comb)))
    else $error("combine or cascade changed while running");

  cfg_start_a: assert property (
    (wr_ctrl && !busy && !stop_entry) |=>
    (st_q.comb == $past(wdata[TMR_COMB_BIT]) &&
     st_q.casc == $past(wdata[TMR_CASC_BIT])))
    else $error("combine or cascade not loaded with a start");

  stop_clears_a: assert property (
    stop_entry |=> (!st_q.run0 && !st_q.run1))
    else $error("deep stop left a run bit set");

  run_clear_a: assert property (
    (!st_q.casc && !st_q.run0) |=> (st_q.cnt[7:0] == 8'h00))
    else $error("stopped timer 0 counter not cleared");

  casc_run_a: assert property (
    (st_q.casc && !st_q.run1 && $stable(st_q.casc)) |=>
    (st_q.cnt == 16'h0000))
    else $error("cascaded pair not cleared by timer 1 stop");

  pin0_high_a: assert property (
    st_q.comb |=> (timer0_pwm_out_pin && timer0_pulse_out_pin))
    else $error("pins 0 not high while outputs are combined");

  pin1_and_a: assert property (
    st_q.comb |=>
    (timer1_pwm_out_pin == ($past(st_q.out0) & $past(st_q.out1))))
    else $error("pins 1 do not carry the AND of both outputs");

  pin_split_a: assert property (
    !st_q.comb |=> (timer0_pwm_out_pin == $past(st_q.out0) &&
                    timer1_pwm_out_pin == $past(st_q.out1)))
    else $error("separate outputs not routed to their pins");

  gate_hold_a: assert property (
    !cken |=> $stable(st_q.cnt) || (st_q.cnt == 16'h0000))
    else $error("counter advanced with the basic clock gated");

  gate_reset_a: assert property (
    $past(!nrst) |-> !cken)
    else $error("clock enable not zero after reset");

  mode_lock_a: assert property (
    (wr && addr == TMR_MODE1_ADDR && st_q.run1) |=> $stable(st_q.mode1))
    else $error("timer 1 mode changed while running");

  casc_src_a: assert property (
    (st_q.casc && st_q.run1 && cken && !tick[1]) |=> $stable(st_q.cnt))
    else $error("cascaded pair counted without a timer 1 tick");

  stop_halts_a: assert property (
    stop_entry |-> ##2 (st_q.cnt == 16'h0000))
    else $error("counter not cleared after deep stop entry");

  run1_clear_a: assert property (
    (!st_q.casc && !st_q.run1) |=> (st_q.cnt[15:8] == 8'h00))
    else $error("stopped timer 1 counter not cleared");

  run_load_a: assert property (
    (wr_ctrl && !stop_entry) |=>
    (st_q.run0 == $past(wdata[TMR_RUN0_BIT]) &&
     st_q.run1 == $past(wdata[TMR_RUN1_BIT])))
    else $error("run bits not loaded from a control write");

  run0_count_a: assert property (
    (cken && !st_q.casc && st_q.run0 && tick[0]) |=>
    (st_q.cnt[7:0] == 8'($past(st_q.cnt[7:0]) + 8'h01)))
    else $error("running timer 0 missed a source tick");

  casc_count_a: assert property (
    (cken && st_q.casc && st_q.run1 && tick[1]) |=>
    (st_q.cnt == 16'($past(st_q.cnt) + 16'h0001)))
    else $error("cascaded pair did not count as one 16-bit value");

  casc_ev_a: assert property (
    (cken && st_q.casc && st_q.run1 && st_q.mode1[TMR_EXT_BIT] &&
     ev_fall[0]) |=> (st_q.cnt == 16'($past(st_q.cnt) + 16'h0001)))
    else $error("cascaded pair missed a timer 0 pin edge");

  casc_pin1_a: assert property (
    (st_q.casc && st_q.run1 && st_q.mode1[TMR_EXT_BIT] && !ev_fall[0])
    |=> $stable(st_q.cnt))
    else $error("cascaded pair counted a timer 1 pin edge");

  mode0_lock_a: assert property (
    (wr && addr == TMR_MODE0_ADDR &&
     (st_q.run0 || (st_q.casc && st_q.run1))) |=> $stable(st_q.mode0))
    else $error("timer 0 mode changed while running");

  mode1_open_a: assert property (
    (wr && addr == TMR_MODE1_ADDR && !st_q.run1) |=>
    (st_q.mode1 == $past(wdata[3:0])))
    else $error("timer 1 mode not loaded while stopped");

  gate_write_a: assert property (
    (wr && addr == TMR_GATE_ADDR) |=>
    (cken == $past(wdata[TMR_CKEN_BIT])))
    else $error("clock enable does not follow its register bit");

  cken_pre_a: assert property (
    !cken |=> $stable(st_q.pre))
    else $error("prescaler ran with the basic clock gated");

  pre_run_a: assert property (
    cken |=> (st_q.pre == 11'($past(st_q.pre) + 11'h1)))
    else $error("prescaler stalled with the basic clock supplied");
endmodule : tmr_pair_ctrl

/* File: testbench/tmr_pair_ctrl_tb.sv */
// self-checking bench for the timer pair run, cascade and gate control
`timescale 1ns/1ns
module tmr_pair_ctrl_tb;
  import tmr_pkg::*;
  logic        clk;
  logic        nrst;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  tmr_pwr_e    pwr_state;
  logic        stop_entry;
  logic        dv9;
  logic        lf_clk;
  logic        lf_en;
  logic [1:0]  ev_pin;
  logic        p0_pwm;
  logic        p0_pul;
  logic        p1_pwm;
  logic        p1_pul;
  logic        cken;
  logic [7:0]  v;
  logic [7:0]  w;
  int          num_errors;
  int          check_count;
  int          cyc;
  int          i;

  tmr_pair_ctrl u_tmr_pair_ctrl (
    .clk                        (clk),
    .nrst                       (nrst),
    .addr                       (addr),
    .wdata                      (wdata),
    .wr                         (wr),
    .rd                         (rd),
    .rdata                      (rdata),
    .pwr_state                  (pwr_state),
    .stop_entry                 (stop_entry),
    .divider_stage_clock_select (dv9),
    .low_freq_clock             (lf_clk),
    .timer_event_input_pin      (ev_pin),
    .timer0_pwm_out_pin         (p0_pwm),
    .timer0_pulse_out_pin       (p0_pul),
    .timer1_pwm_out_pin         (p1_pwm),
    .timer1_pulse_out_pin       (p1_pul),
    .timer_pair_clock_enable    (cken)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // slow clock only runs when enabled: one rise every four bus cycles
  always @(posedge clk)
  begin
    if (lf_en && cyc % 2 == 0)
      lf_clk <= ~lf_clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // second write clears cascade and combine once the run bits are down
  task automatic stop_all();
    wr_reg(TMR_CTRL_ADDR, 8'h00);
    wr_reg(TMR_CTRL_ADDR, 8'h00);
  endtask : stop_all

  task automatic t_reset_regs();
    check(cken, 1'b0);
    rd_reg(TMR_GATE_ADDR, v);
    check(v, 8'h00);
    // clock enable goes up before any timer control register is touched
    wr_reg(TMR_GATE_ADDR, 8'h10);
    #1;
    check(cken, 1'b1);
    rd_reg(TMR_GATE_ADDR, v);
    check(v, 8'h10);
    rd_reg(TMR_CTRL_ADDR, v);
    check(v, 8'h00);
    rd_reg(12'h7f0, v);
    check(v, 8'h00);
    $display("test reset_regs done");
  endtask : t_reset_regs

  task automatic t_ctrl_bits();
    wr_reg(TMR_CTRL_ADDR, 8'hfc);
    rd_reg(TMR_CTRL_ADDR, v);
    check(v, 8'h0c);
    wr_reg(TMR_CTRL_ADDR, 8'h00);
    wr_reg(TMR_CTRL_ADDR, 8'h05);
    rd_reg(TMR_CTRL_ADDR, v);
    check(v, 8'h05);
    wr_reg(TMR_CTRL_ADDR, 8'h0b);
    rd_reg(TMR_CTRL_ADDR, v);
    check(v, 8'h07);
    wr_reg(TMR_CTRL_ADDR, 8'h00);
    rd_reg(TMR_CTRL_ADDR, v);
    check(v, 8'h04);
    stop_all();
    $display("test ctrl_bits done");
  endtask : t_ctrl_bits

  task automatic t_count_run();
    pwr_state <= TMR_PWR_IDLE;
    wr_reg(TMR_MODE0_ADDR, 8'h07);
    wr_reg(TMR_CTRL_ADDR, 8'h01);
    wr_reg(TMR_MODE0_ADDR, 8'h00);
    rd_reg(TMR_MODE0_ADDR, v);
    check(v, 8'h07);
    rd_reg(TMR_CNTLO_ADDR, v);
    rd_reg(TMR_CNTLO_ADDR, w);
    check(8'(w - v), 8'h02);
    stop_all();
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v, 8'h00);
    wr_reg(TMR_MODE1_ADDR, 8'h07);
    wr_reg(TMR_CTRL_ADDR, 8'h06);
    rd_reg(TMR_CNTLO_ADDR, v);
    rd_reg(TMR_CNTLO_ADDR, w);
    check(8'(w - v), 8'h02);
    wr_reg(TMR_MODE1_ADDR, 8'h00);
    rd_reg(TMR_MODE1_ADDR, v);
    check(v, 8'h07);
    stop_all();
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v, 8'h00);
    wr_reg(TMR_CTRL_ADDR, 8'h01);
    @(posedge clk);
    stop_entry <= 1'b1;
    @(posedge clk);
    stop_entry <= 1'b0;
    rd_reg(TMR_CTRL_ADDR, v);
    check(v[1:0], 2'h0);
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v, 8'h00);
    stop_all();
    pwr_state <= TMR_PWR_NORMAL;
    $display("test count_run done");
  endtask : t_count_run

  task automatic t_pins();
    wr_reg(TMR_CTRL_ADDR, 8'h01);
    for (i = 0; i < 300 && p0_pwm !== 1'b1; i++)
      @(posedge clk);
    check(p0_pwm, 1'b1);
    check(p0_pul, 1'b1);
    check(p1_pwm, 1'b0);
    stop_all();
    wr_reg(TMR_CTRL_ADDR, 8'h0b);
    repeat (2) @(posedge clk);
    #1;
    check({p0_pwm, p0_pul, p1_pwm}, 3'b110);
    for (i = 0; i < 300 && p1_pwm !== 1'b1; i++)
      @(posedge clk);
    #1;
    check({p1_pwm, p1_pul, p0_pwm}, 3'b111);
    stop_all();
    $display("test pins done");
  endtask : t_pins

  task automatic t_sources();
    dv9 <= 1'b1;
    wr_reg(TMR_MODE0_ADDR, 8'h00);
    wr_reg(TMR_CTRL_ADDR, 8'h01);
    repeat (100) @(posedge clk);
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v, 8'h00);
    stop_all();
    dv9       <= 1'b0;
    pwr_state <= TMR_PWR_SLOW;
    lf_en     <= 1'b1;
    wr_reg(TMR_MODE0_ADDR, 8'h03);
    wr_reg(TMR_CTRL_ADDR, 8'h01);
    repeat (100) @(posedge clk);
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v, 8'h00);
    stop_all();
    pwr_state <= TMR_PWR_SLEEP;
    wr_reg(TMR_MODE0_ADDR, 8'h07);
    wr_reg(TMR_CTRL_ADDR, 8'h01);
    repeat (160) @(posedge clk);
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v >= 8'h09 && v <= 8'h0b, 1'b1);
    stop_all();
    lf_en     <= 1'b0;
    pwr_state <= TMR_PWR_NORMAL;
    $display("test sources done");
  endtask : t_sources

  task automatic t_events();
    wr_reg(TMR_MODE0_ADDR, 8'h08);
    wr_reg(TMR_MODE1_ADDR, 8'h08);
    wr_reg(TMR_CTRL_ADDR, 8'h03);
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk);
      ev_pin <= (i < 3) ? 2'b00 : 2'b10;
      repeat (4) @(posedge clk);
      ev_pin <= 2'b11;
      repeat (4) @(posedge clk);
    end
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v, 8'h05);
    rd_reg(TMR_CNTHI_ADDR, v);
    check(v, 8'h03);
    stop_all();
    // cascaded: only timer 0's pin may advance the pair
    wr_reg(TMR_CTRL_ADDR, 8'h06);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      ev_pin <= (i < 2) ? 2'b10 : 2'b01;
      repeat (4) @(posedge clk);
      ev_pin <= 2'b11;
      repeat (4) @(posedge clk);
    end
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v, 8'h02);
    rd_reg(TMR_CNTHI_ADDR, v);
    check(v, 8'h00);
    stop_all();
    wr_reg(TMR_GATE_ADDR, 8'h00);
    #1;
    check(cken, 1'b0);
    wr_reg(TMR_MODE0_ADDR, 8'h07);
    wr_reg(TMR_CTRL_ADDR, 8'h01);
    repeat (20) @(posedge clk);
    rd_reg(TMR_CNTLO_ADDR, v);
    check(v, 8'h00);
    stop_all();
    $display("test events done");
  endtask : t_events

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    nrst        = 1'b0;
    addr        = 12'h000;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    pwr_state   = TMR_PWR_NORMAL;
    stop_entry  = 1'b0;
    dv9         = 1'b0;
    lf_clk      = 1'b0;
    lf_en       = 1'b0;
    ev_pin      = 2'b11;
    num_errors  = 0;
    check_count = 0;
    cyc         = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset_regs();
    t_ctrl_bits();
    t_count_run();
    t_pins();
    t_sources();
    t_events();
    tally_and_finish();
  end
endmodule : tmr_pair_ctrl_tb
